// >>> rtl/awt_loop.sv
// adaptive wake threshold tracking loop with its register set
//
// Summary of operation
// - trip count field sits in control byte 0x3 bits 6:5; code 00 disables speedup.
// - speedup engages after 2, 4 or 6 same-direction trips for codes 01, 10, 11.
// - engaged speedup runs the loop sampling sixteen times faster.
// - a same-direction run is successive up trips or successive down trips, counted even while a limit holds the gain.
// - byte 0x4 bit 5 picks sampling interval: low 1 s, high 0.5 s.
// - tracked gain code never goes above upper limit, nor below lower limit unless the limits cross.
// - both limit fields accept any five-bit code up to 11111.
// - margin code sets trip level at (code+1) times the average level.
// - wake flag trips when input exceeds average level by the margin.
// - byte 0x2 bits 3:2 hold the wake high-pass corner selection.
// - corner codes 00,01,10,11 mean 200, 300, 400, 800 Hz.
// - gain code maps to threshold in 1.5 dB steps and stays readable.
// - writing 1 to the clear bit drops the wake flag unless a trip lands in the same cycle, and re-arms detection.
`timescale 1ns/10ps
`include "awt_cfg.svh"

module awt_loop
	import awt_pkg::*;
#(
	parameter logic [27:0] INTERVAL_CYC = 28'(`AWT_INTERVAL_CYC)
) (
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire awt_req_t  req,
	output logic [7:0]     rdata,
	input  wire awt_trip_t trip,
	input  wire logic [7:0] sig_level,
	input  wire logic [7:0] avg_level,
	output logic           wake_flag,
	output logic [4:0]     ambient_gain_code,
	output logic [1:0]     wake_highpass_corner,
	output logic [1:0]     wake_lowpass_corner,
	output logic           fast_active
);

	function automatic logic [2:0] need_trips(input logic [1:0] code);
		case (code)
			2'h1:    need_trips = 3'h2;
			2'h2:    need_trips = 3'h4;
			2'h3:    need_trips = 3'h6;
			default: need_trips = 3'h0;
		endcase
	endfunction

	function automatic logic [4:0] clamp(input logic [4:0] v, input logic [4:0] lo,
		input logic [4:0] hi);
		logic [4:0] r;
		r = v;
		if (r < lo) begin
			r = lo;
		end
		// upper bound applied last so it wins if the limits cross
		if (r > hi) begin
			r = hi;
		end
		clamp = r;
	endfunction

	// register state
	logic [7:0] filter;
	logic [7:0] floor_reg;
	logic [7:0] ceil_reg;
	logic [7:0] margin;
	logic [7:0] next_filter;
	logic [7:0] next_floor_reg;
	logic [7:0] next_ceil_reg;
	logic [7:0] next_margin;
	logic [7:0] next_rdata;
	logic       clear_wr;

	// loop state
	logic [27:0] tmr;
	logic [27:0] next_tmr;
	logic [27:0] period;
	logic        tick;
	logic [4:0]  gain;
	logic [4:0]  next_gain;
	logic [2:0]  run;
	logic [2:0]  next_run;
	logic        last_up;
	logic        next_last_up;
	logic        fast;
	logic        next_fast;
	logic        next_wake;
	logic        trip_now;
	logic [10:0] trip_level;
	logic        step_up;
	logic        step_dn;

	logic [4:0] lower_lim;
	logic [4:0] upper_lim;
	logic [1:0] cnt_code;

	assign lower_lim = floor_reg[`AWT_LIM_MSB:0];
	assign upper_lim = ceil_reg[`AWT_LIM_MSB:0];
	assign cnt_code  = floor_reg[`AWT_CNT_MSB:`AWT_CNT_LSB];
	assign clear_wr  = req.wr && req.addr == `AWT_OFS_CTRL && req.wdata[`AWT_CLEAR_BIT];

	always_comb begin
		next_filter = filter;
		next_floor_reg = floor_reg;
		next_ceil_reg = ceil_reg;
		next_margin = margin;
		next_rdata = rdata;
		if (req.wr) begin
			case (req.addr)
				`AWT_OFS_FILTER: next_filter = req.wdata & `AWT_MASK_FILTER;
				`AWT_OFS_FLOOR:  next_floor_reg = req.wdata & `AWT_MASK_FLOOR;
				`AWT_OFS_CEIL:   next_ceil_reg = req.wdata & `AWT_MASK_CEIL;
				`AWT_OFS_MARGIN: next_margin = req.wdata & `AWT_MASK_MARGIN;
				default:         ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				// clear bit is a strobe, so it always reads back zero
				`AWT_OFS_CTRL:   next_rdata = 8'h00;
				`AWT_OFS_GAIN:   next_rdata = {3'h0, gain};
				`AWT_OFS_FILTER: next_rdata = filter;
				`AWT_OFS_FLOOR:  next_rdata = floor_reg;
				`AWT_OFS_CEIL:   next_rdata = ceil_reg;
				`AWT_OFS_MARGIN: next_rdata = margin;
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			filter <= `AWT_RST_FILTER;
			floor_reg <= `AWT_RST_FLOOR;
			ceil_reg <= `AWT_RST_CEIL;
			margin <= `AWT_RST_MARGIN;
			rdata <= 8'h00;
		end else begin
			filter <= next_filter;
			floor_reg <= next_floor_reg;
			ceil_reg <= next_ceil_reg;
			margin <= next_margin;
			rdata <= next_rdata;
		end
	end

	// sampling interval: half when rms bit set, a sixteenth while sped up
	always_comb begin
		period = ceil_reg[`AWT_RMS_BIT] ? (INTERVAL_CYC >> 1) : INTERVAL_CYC;
		if (fast) begin
			period = period / 28'(`AWT_FAST_DIV);
		end
	end
	// >= rather than == so a shortened period takes effect at once
	assign tick = tmr >= period - 28'h1;
	assign step_up = tick && trip.quieter && !trip.louder;
	assign step_dn = tick && trip.louder && !trip.quieter;

	always_comb begin
		next_tmr = tick ? 28'h0 : tmr + 28'h1;
		next_gain = clamp(gain, lower_lim, upper_lim);
		next_run = run;
		next_last_up = last_up;
		next_fast = fast;
		if (step_up || step_dn) begin
			// louder ambient lowers the code, i.e. raises the threshold
			if (step_up && gain != 5'h1f) begin
				next_gain = clamp(gain + 5'h1, lower_lim, upper_lim);
			end else if (step_dn && gain != 5'h00) begin
				next_gain = clamp(gain - 5'h1, lower_lim, upper_lim);
			end
			next_last_up = step_up;
			if (step_up == last_up && run != 3'h0) begin
				next_run = (run == 3'h7) ? run : run + 3'h1;
			end else begin
				next_run = 3'h1;
			end
			next_fast = cnt_code != 2'h0 && next_run >= need_trips(cnt_code);
		end
		if (cnt_code == 2'h0) begin
			next_fast = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr <= 28'h0;
			gain <= `AWT_RST_GAIN;
			run <= 3'h0;
			last_up <= 1'b0;
			fast <= 1'b0;
		end else begin
			tmr <= next_tmr;
			gain <= next_gain;
			run <= next_run;
			last_up <= next_last_up;
			fast <= next_fast;
		end
	end

	// trip level is (code+1) times the average; code 0 sits on the average itself
	assign trip_level = 11'(avg_level) * (11'(margin[2:0]) + 11'h1);
	assign trip_now = 11'(sig_level) > trip_level;
	// a new trip in the clearing cycle wins so no event is lost
	assign next_wake = trip_now || (wake_flag && !clear_wr);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_flag <= 1'b0;
		end else begin
			wake_flag <= next_wake;
		end
	end

	assign ambient_gain_code = gain;
	assign wake_highpass_corner = filter[`AWT_HPF_MSB:`AWT_HPF_LSB];
	assign wake_lowpass_corner = filter[`AWT_LPF_MSB:`AWT_LPF_LSB];
	assign fast_active = fast;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// limit checks skip crossed limits, where the upper one wins by design
	gain_limit_a: assert property (tick && lower_lim <= upper_lim
		|=> gain <= $past(upper_lim) && gain >= $past(lower_lim))
		else $error("gain left its limits");
	gain_step_a: assert property (step_up && gain < upper_lim && gain >= lower_lim
		|=> gain == $past(gain) + 5'h1)
		else $error("gain did not step up by one");
	gain_down_a: assert property (step_dn && gain > lower_lim && gain <= upper_lim
		|=> gain == $past(gain) - 5'h1)
		else $error("gain did not step down by one");
	gain_hold_a: assert property (!tick && !req.wr && gain >= lower_lim
		&& gain <= upper_lim |=> gain == $past(gain))
		else $error("gain moved between samples");
	fast_engage_a: assert property (tick && step_up && last_up && run == 3'h1
		&& cnt_code == 2'h1 && !req.wr |=> fast)
		else $error("speedup missed after two trips");
	fast_four_a: assert property (cnt_code == 2'h2 && run == 3'h3
		&& ((step_up && last_up) || (step_dn && !last_up)) |=> fast)
		else $error("speedup missed after four trips");
	fast_six_a: assert property (cnt_code == 2'h3 && run == 3'h5
		&& ((step_up && last_up) || (step_dn && !last_up)) |=> fast)
		else $error("speedup missed after six trips");
	fast_early_a: assert property (cnt_code == 2'h3 && run < 3'h4
		&& (step_up || step_dn) |=> !fast)
		else $error("speedup engaged too early");
	fast_off_a: assert property (cnt_code == 2'h0 |=> !fast)
		else $error("speedup active while disabled");
	run_count_a: assert property (step_dn && !last_up && run == 3'h2
		|=> run == 3'h3)
		else $error("same-direction run not counted");
	run_restart_a: assert property ((step_up && !last_up) || (step_dn && last_up)
		|=> run == 3'h1)
		else $error("run not restarted on reversal");
	fast_rate_a: assert property (fast && !ceil_reg[`AWT_RMS_BIT]
		|-> period == INTERVAL_CYC / 28'(`AWT_FAST_DIV))
		else $error("sped-up period wrong");
	fast_half_a: assert property (fast && ceil_reg[`AWT_RMS_BIT]
		|-> period == (INTERVAL_CYC >> 1) / 28'(`AWT_FAST_DIV))
		else $error("sped-up half interval wrong");
	half_rate_a: assert property (!fast && ceil_reg[`AWT_RMS_BIT]
		|-> period == (INTERVAL_CYC >> 1))
		else $error("half interval wrong");
	full_rate_a: assert property (!fast && !ceil_reg[`AWT_RMS_BIT]
		|-> period == INTERVAL_CYC)
		else $error("full interval wrong");
	wake_set_a: assert property (trip_now |=> wake_flag)
		else $error("wake flag missed a trip");
	wake_quiet_a: assert property (!wake_flag && !trip_now |=> !wake_flag)
		else $error("wake flag rose without a trip");
	wake_clear_a: assert property (clear_wr && !trip_now |=> !wake_flag)
		else $error("wake flag not cleared");
	wake_hold_a: assert property (wake_flag && !clear_wr |=> wake_flag)
		else $error("wake flag dropped without a clear");
	gain_read_a: assert property (req.rd && req.addr == `AWT_OFS_GAIN
		|=> rdata == {3'h0, $past(gain)})
		else $error("gain readback wrong");
	limit_write_a: assert property (req.wr && req.addr == `AWT_OFS_FLOOR
		|=> lower_lim == $past(req.wdata[4:0]))
		else $error("lower limit not stored");
	ceil_write_a: assert property (req.wr && req.addr == `AWT_OFS_CEIL
		|=> upper_lim == $past(req.wdata[4:0]))
		else $error("upper limit not stored");
	corner_write_a: assert property (req.wr && req.addr == `AWT_OFS_FILTER
		|=> wake_highpass_corner == $past(req.wdata[`AWT_HPF_MSB:`AWT_HPF_LSB]))
		else $error("high-pass corner not stored");
	margin_write_a: assert property (req.wr && req.addr == `AWT_OFS_MARGIN
		|=> margin == {5'h0, $past(req.wdata[2:0])})
		else $error("margin code not stored");

	fast_seen_c: cover property (!fast ##1 fast);
	fast_six_c: cover property (fast && cnt_code == 2'h3);
	wake_clr_c: cover property (wake_flag ##1 clear_wr ##1 !wake_flag);
	gain_top_c: cover property (step_up && gain == upper_lim);
	reversal_c: cover property (step_up ##[1:20] step_dn);

endmodule

// >>> rtl/awt_cfg.svh
// offsets, field positions, reset values and timing counts of the wake threshold loop
`ifndef AWT_CFG_SVH
`define AWT_CFG_SVH

`define AWT_OFS_CTRL        8'h00
`define AWT_OFS_GAIN        8'h01
`define AWT_OFS_FILTER      8'h02
`define AWT_OFS_FLOOR       8'h03
`define AWT_OFS_CEIL        8'h04
`define AWT_OFS_MARGIN      8'h05

`define AWT_CLEAR_BIT       4
`define AWT_HPF_MSB         3
`define AWT_HPF_LSB         2
`define AWT_LPF_MSB         1
`define AWT_LPF_LSB         0
`define AWT_CNT_MSB         6
`define AWT_CNT_LSB         5
`define AWT_RMS_BIT         5
`define AWT_LIM_MSB         4

`define AWT_RST_FILTER      8'h0c
`define AWT_RST_FLOOR       8'h40
`define AWT_RST_CEIL        8'h1b
`define AWT_RST_MARGIN      8'h07
`define AWT_RST_GAIN        5'h10

`define AWT_MASK_FILTER     8'h0f
`define AWT_MASK_FLOOR      8'h7f
`define AWT_MASK_CEIL       8'h3f
`define AWT_MASK_MARGIN     8'h07

`define AWT_CLK_HZ          250000000
`define AWT_INTERVAL_S      1
`define AWT_INTERVAL_CYC    (`AWT_INTERVAL_S * `AWT_CLK_HZ)
`define AWT_FAST_DIV        16

`endif

// >>> rtl/awt_pkg.sv
// types shared by the wake threshold loop
package awt_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} awt_req_t;

	typedef struct packed {
		logic louder;
		logic quieter;
	} awt_trip_t;
endpackage

// >>> bench/awt_front_model.sv
// behavioural acoustic front end that steers the comparator toward a target gain
`timescale 1ns/10ps

module awt_front_model
	import awt_pkg::*;
(
	input  wire logic [4:0] gain,
	input  wire logic [4:0] target,
	input  wire logic       clk,
	output awt_trip_t       trip
);
	// drives on the falling edge so the loop samples a settled level
	always @(negedge clk) begin
		trip.quieter <= gain < target;
		trip.louder  <= gain > target;
	end
endmodule

// >>> bench/adaptive_wake_threshold_loop_bench.sv
// self-checking bench for the wake threshold loop
`timescale 1ns/10ps

module adaptive_wake_threshold_loop_bench
	import awt_pkg::*;
;
	localparam int P = 64;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	awt_req_t   req = '0;
	logic [7:0] rdata;
	logic [7:0] sig_level = 8'h00;
	logic [7:0] avg_level = 8'h14;
	awt_trip_t  trip;
	logic       wake_flag;
	logic       fast_active;
	logic       fprev;
	logic [4:0] gain;
	logic [4:0] target = 5'h10;
	logic [1:0] hpf;
	logic [1:0] lpf;
	logic [7:0] msk[6] = '{8'h00, 8'h00, 8'h0f, 8'h7f, 8'h3f, 8'h07};
	logic [4:0] tgt[3] = '{5'h10, 5'h0a, 5'h12};
	logic       rms[3] = '{1'b1, 1'b0, 1'b0};
	int         err_total = 0;
	int         n_checks = 0;
	int         dt;

	always #2 clk = ~clk;

	awt_loop #(.INTERVAL_CYC(28'(P))) dut_u (.clk(clk), .rst(rst), .req(req),
		.rdata(rdata), .trip(trip), .sig_level(sig_level), .avg_level(avg_level),
		.wake_flag(wake_flag), .ambient_gain_code(gain), .wake_highpass_corner(hpf),
		.wake_lowpass_corner(lpf), .fast_active(fast_active));

	awt_front_model front_u (.gain(gain), .target(target), .clk(clk), .trip(trip));

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req <= '0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req <= '0;
		chk("register read", e, rdata);
	endtask

	// counts whole cycles between gain steps; entered and left on a falling edge
	task automatic wait_change(output int n);
		logic [4:0] g;
		g = gain;
		n = 0;
		while (gain === g && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) chk("gain step", 1, 0);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		chk("hpf", 2'h3, hpf);
		chk("speedup", 0, fast_active);
		chk_rd(8'h00, 8'h00);
		chk_rd(8'h01, 8'h10);
		chk_rd(8'h03, 8'h40);
		chk_rd(8'h04, 8'h1b);
		chk_rd(8'h05, 8'h07);
		wr(8'h06, 8'hff);
		chk_rd(8'h06, 8'h00);
		target = 5'h1f;
		wr(8'h01, 8'h00);
		chk_rd(8'h01, 8'h10);
		for (int a = 2; a < 6; a++) begin
			wr(8'(a), 8'hff);
			chk_rd(8'(a), msk[a]);
		end
		chk("gain at top", 5'h1f, gain);
		for (int c = 0; c < 4; c++) begin
			wr(8'h02, {4'h0, 2'(c), 2'(3 - c)});
			@(negedge clk);
			chk("hpf", c, hpf);
			chk("lpf", 3 - c, lpf);
		end
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h1f);
		target = 5'h10;
		for (int k = 1; k < 16; k++) begin
			wait_change(dt);
			chk("gain down", 5'h1f - 5'(k), gain);
			if (k > 1) chk("interval", P, dt);
		end
		target = 5'h1f;
		wr(8'h04, 8'h14);
		repeat (800) @(negedge clk);
		chk("gain ceiling", 5'h14, gain);
		wr(8'h04, 8'h11);
		repeat (2) @(negedge clk);
		chk("gain reclamp", 5'h11, gain);
		target = 5'h00;
		wr(8'h03, 8'h0c);
		repeat (500) @(negedge clk);
		chk("gain floor", 5'h0c, gain);
		chk_rd(8'h01, 8'h0c);
		// each run opens with a reversal, so the run count restarts at one
		for (int i = 0; i < 3; i++) begin
			wr(8'h04, {2'h0, rms[i], 5'h1f});
			wr(8'h03, {1'h0, 2'(i + 1), 5'h00});
			target = tgt[i];
			for (int k = 1; k <= 2 * i + 4; k++) begin
				fprev = fast_active;
				wait_change(dt);
				if (k > 1) chk("interval", (fprev ? P / 16 : P) >> rms[i], dt);
				chk("speedup", k >= 2 * i + 2, fast_active);
			end
		end
		wr(8'h03, 8'h00);
		repeat (2) @(negedge clk);
		chk("speedup off", 0, fast_active);
		// margin 000 is never used: it sits on the noise floor
		for (int c = 1; c < 8; c++) begin
			wr(8'h05, 8'(c));
			sig_level = 8'(20 * (c + 1));
			repeat (2) @(negedge clk);
			chk("wake at margin", 0, wake_flag);
			sig_level = 8'(20 * (c + 1) + 1);
			repeat (2) @(negedge clk);
			chk("wake over margin", 1, wake_flag);
			sig_level = 8'h00;
			repeat (2) @(negedge clk);
			chk("wake held", 1, wake_flag);
			wr(8'h00, 8'h10);
			@(negedge clk);
			chk("wake cleared", 0, wake_flag);
		end
		tally_and_finish();
	end
endmodule
